// ===== aomc_pkg.sv
// package: link constants, register layout and state encodings for both ends
`default_nettype none
package aomc_pkg;
   // ==========================================================
   // serial register addresses and command
   localparam logic [5:0] A_STATUS = 6'h00;
   localparam logic [5:0] A_MODE = 6'h01;
   localparam logic [5:0] A_IFMODE = 6'h02;
   localparam logic [5:0] A_DATA = 6'h04;
   localparam logic [5:0] A_CHEN = 6'h10;
   localparam logic [5:0] A_OFFSET = 6'h30;
   localparam logic [5:0] A_GAIN = 6'h38;
   localparam int RD_BIT = 6;
   localparam logic [7:0] CMD_RD_DATA = 8'h44;
   localparam logic [5:0] LEN_BYTE = 6'h08;
   localparam logic [5:0] LEN_WORD = 6'h18;
   localparam logic [5:0] LEN_DATA_ST = 6'h20;
   // ==========================================================
   // field positions and mode encodings
   localparam int MODE_LSB = 4;
   localparam int CLKSEL_LSB = 2;
   localparam int IF_CONTINUOUS_READ_ENABLE = 7;
   localparam int IF_APPEND = 6;
   localparam int IF_UNIPOLAR = 0;
   localparam logic [2:0] M_CONT = 3'h0;
   localparam logic [2:0] M_SINGLE = 3'h1;
   localparam logic [2:0] M_STANDBY = 3'h2;
   localparam logic [2:0] M_PDOWN = 3'h3;
   localparam logic [2:0] M_ICAL_Z = 3'h4;
   localparam logic [2:0] M_ICAL_F = 3'h5;
   localparam logic [2:0] M_SCAL_Z = 3'h6;
   localparam logic [2:0] M_SCAL_F = 3'h7;
   localparam logic [1:0] CLKSEL_INT = 2'h0;
   // ==========================================================
   // power-on values and scaling constants
   localparam logic [23:0] MODE_RST = 24'h00_0000;
   localparam logic [23:0] IFMODE_RST = 24'h00_0000;
   localparam logic [23:0] CHEN_RST = 24'h00_0001;
   localparam logic [23:0] OFFSET_RST = 24'h80_0000;
   localparam logic [23:0] GAIN_RST = 24'h55_5550;
   localparam logic [23:0] MID_SCALE = 24'h80_0000;
   localparam logic [23:0] GAIN_ONE = 24'h40_0000;
   localparam int GAIN_SHIFT = $clog2(GAIN_ONE);
   localparam int CH_N = 16;
   // ==========================================================
   // link timing
   localparam int SRST_CLKS = 64;
   localparam int SCLK_HALF = 8;
   localparam int CLK_MHZ = 50;
   localparam int RESET_WAIT_US = 500;
   localparam int RESET_WAIT_CYC = RESET_WAIT_US * CLK_MHZ;
   // ==========================================================
   // host command port
   localparam logic [3:0] HA_CTRL = 4'h0;
   localparam logic [3:0] HA_TXD = 4'h4;
   localparam logic [3:0] HA_RXD = 4'h8;
   localparam logic [3:0] HA_STAT = 4'hC;
   localparam int C_SKIP = 14;
   localparam int C_SRST = 15;
   localparam int C_HOLD = 16;

   typedef enum logic [1:0] {SP_CMD = 2'b00, SP_WR = 2'b01, SP_RD = 2'b11} aomc_sp_e;
   typedef enum logic [1:0] {CV_IDLE = 2'b00, CV_RUN = 2'b01, CV_DOWN = 2'b11} aomc_cv_e;
   typedef enum logic [1:0] {H_IDLE = 2'b00, H_XFER = 2'b01, H_WAIT = 2'b11} aomc_hp_e;

   function automatic logic [5:0] reg_len(input logic [5:0] a, input logic app);
      logic [5:0] r;
      r = LEN_WORD;
      if (a == A_STATUS) begin
         r = LEN_BYTE;
      end else if (a == A_DATA && app) begin
         r = LEN_DATA_ST;
      end
      return r;
   endfunction
endpackage
`default_nettype wire

// ===== aomc_link_if.sv
// interface: four-wire serial link between converter and host
`default_nettype none
interface aomc_link_if;
   logic cs_b;
   logic sclk;
   logic din;
   logic dout;
   logic dout_oe;
   logic dout_line;
   // released line reads high through the pull-up
   assign dout_line = dout_oe ? dout : 1'b1;
   modport dev (input cs_b, input sclk, input din, output dout, output dout_oe);
   modport host (output cs_b, output sclk, output din, input dout_line);
endinterface
`default_nettype wire

// ===== aomc_dev.sv
// converter end: operating modes, sequencing, calibration and serial slave
//
// How it works
// - power-up continuous; ready flag and pin fall
// - command first; busy data read drops result
// - convert enabled channels ascending, then wrap
// - load each result, ready low till read, read overlaps
// - append bit adds status; low nibble channel
// - continuous read: clocks only, one read
// - unread result replaced by newest one
// - continuous read needs continuous mode
// - exit by 0x44 while ready low, or reset
// - host holds data input low meanwhile
// - single conversion then standby; re-read allowed
// - single multi-channel: each once, then standby
// - standby stops clock with internal source
// - power-down only from standby; outputs released
// - power-down left only by serial reset
// - calibration uses one channel; results stored unscaled
// - scale by offset and gain, per polarity
// - calibration raises ready, updates, then standby
// - internal calibrations route inputs automatically
// - calibration lasts one settling; offset first
// - coefficients locked during internal calibration
// - host recalibrates offset after reference change
// - serial reset restores power-on register values
//
// The strobed register port and the placing of the registers are this design's own decisions.
`default_nettype none
module aomc_dev (
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   input wire logic ce,
   // serial link
   aomc_link_if.dev link,
   // filter side
   input wire logic conv_done,
   input wire logic [23:0] conv_raw,
   output logic conv_start,
   output logic [3:0] conv_ch,
   output logic cal_zero_route,
   output logic cal_fs_route,
   // power control
   output logic clk_run,
   output logic gpio_hiz
);
   import aomc_pkg::*;

   typedef struct packed {
      logic sclk_s1;
      logic sclk_s2;
      logic sclk_d;
      logic cs_s1;
      logic cs_s2;
      logic din_s1;
      logic din_s2;
      aomc_sp_e sp;
      logic [5:0] cnt;
      logic [5:0] len;
      logic [5:0] addr;
      logic [22:0] rx;
      logic [31:0] tx;
      logic obit;
      logic rd_data;
      logic [6:0] srst_cnt;
      aomc_cv_e cv;
      logic kick;
      logic [3:0] cur_ch;
      logic [23:0] mode;
      logic [23:0] ifmode;
      logic [23:0] chen;
      logic [23:0] offset;
      logic [23:0] gain;
      logic [23:0] data;
      logic [3:0] data_ch;
      logic rdy_b;
      logic conv_start;
      logic cal_zero;
      logic cal_fs;
      logic clk_run;
      logic gpio_hiz;
      logic dout;
      logic dout_oe;
   } aomc_dev_s;

   // ==========================================================
   // helpers
   function automatic aomc_dev_s power_on();
      aomc_dev_s v;
      v = '0;
      v.sclk_s1 = 1'b1;
      v.sclk_s2 = 1'b1;
      v.sclk_d = 1'b1;
      v.cs_s1 = 1'b1;
      v.cs_s2 = 1'b1;
      v.sp = SP_CMD;
      v.cv = CV_IDLE;
      v.kick = 1'b1;
      v.cur_ch = 4'hF;
      v.mode = MODE_RST;
      v.ifmode = IFMODE_RST;
      v.chen = CHEN_RST;
      v.offset = OFFSET_RST;
      v.gain = GAIN_RST;
      v.rdy_b = 1'b1;
      v.clk_run = 1'b1;
      v.dout = 1'b1;
      return v;
   endfunction

   localparam aomc_dev_s RST = power_on();

   // lowest enabled channel above cur, else lowest enabled
   function automatic logic [3:0] next_ch(input logic [23:0] en, input logic [3:0] cur);
      logic [3:0] r;
      r = cur;
      for (int i = CH_N - 1; i >= 0; i--) begin
         if (en[i]) begin
            r = 4'(i);
         end
      end
      for (int i = CH_N - 1; i >= 0; i--) begin
         if (en[i] && 4'(i) > cur) begin
            r = 4'(i);
         end
      end
      return r;
   endfunction

   // clamps instead of wrapping so an overrange input reads full scale
   function automatic logic [23:0] scale(input logic [23:0] raw, input logic [23:0] off,
                                          input logic [23:0] gn, input logic uni);
      logic signed [25:0] d;
      logic signed [51:0] p;
      logic [23:0] r;
      d = $signed({2'b00, raw}) - ($signed({2'b00, off}) - $signed({2'b00, MID_SCALE}));
      p = d * $signed({2'b00, gn});
      p = p >>> GAIN_SHIFT;
      p = uni ? (p <<< 1) : (p + $signed({28'h000_0000, MID_SCALE}));
      if (p < 0) begin
         r = '0;
      end else if (p > $signed({28'h000_0000, 24'hFF_FFFF})) begin
         r = 24'hFF_FFFF;
      end else begin
         r = p[23:0];
      end
      return r;
   endfunction

   aomc_dev_s s;
   aomc_dev_s n;

   // ==========================================================
   // next state
   always_comb begin
      logic rise;
      logic fall;
      logic cs_on;
      logic srst;
      logic wr;
      logic mwr;
      logic continuous_read_enable;
      logic app;
      logic ical;
      logic [2:0] mf;
      logic [2:0] nmf;
      logic [7:0] st;
      logic [7:0] by;
      logic [23:0] w;
      logic [23:0] v;
      logic [31:0] tw;
      logic [3:0] nc;
      aomc_dev_s t;
      rise = 1'b0;
      fall = 1'b0;
      cs_on = 1'b0;
      srst = 1'b0;
      wr = 1'b0;
      mwr = 1'b0;
      v = '0;
      nc = '0;
      t = RST;
      n = s;
      n.conv_start = 1'b0;
      n.sclk_s1 = link.sclk;
      n.sclk_s2 = s.sclk_s1;
      n.sclk_d = s.sclk_s2;
      n.cs_s1 = link.cs_b;
      n.cs_s2 = s.cs_s1;
      n.din_s1 = link.din;
      n.din_s2 = s.din_s1;
      rise = s.sclk_s2 & ~s.sclk_d;
      fall = ~s.sclk_s2 & s.sclk_d;
      cs_on = ~s.cs_s2;
      mf = s.mode[MODE_LSB +: 3];
      continuous_read_enable = s.ifmode[IF_CONTINUOUS_READ_ENABLE];
      app = s.ifmode[IF_APPEND];
      ical = (s.cv == CV_RUN) && (mf == M_ICAL_Z || mf == M_ICAL_F);
      st = {s.rdy_b, 3'b000, s.data_ch};
      by = {s.rx[6:0], s.din_s2};
      w = {s.rx, s.din_s2};
      case (by[5:0])
         A_STATUS: tw = {st, 24'h00_0000};
         A_MODE: tw = {s.mode, 8'h00};
         A_IFMODE: tw = {s.ifmode, 8'h00};
         A_CHEN: tw = {s.chen, 8'h00};
         A_DATA: tw = {s.data, st};
         A_OFFSET: tw = ical ? '0 : {s.offset, 8'h00};
         A_GAIN: tw = ical ? '0 : {s.gain, 8'h00};
         default: tw = '0;
      endcase

      // serial reset counts consecutive high data bits
      if (!cs_on) begin
         n.srst_cnt = '0;
      end else if (rise) begin
         n.srst_cnt = s.din_s2 ? s.srst_cnt + 7'h01 : '0;
      end
      srst = cs_on && rise && s.din_s2 && (s.srst_cnt == 7'(SRST_CLKS - 1));

      // a continuous-read result stays armed across a deselect
      if (!cs_on) begin
         if (!(continuous_read_enable && s.sp == SP_RD)) begin
            n.sp = SP_CMD;
            n.cnt = '0;
         end
      end else if (s.cv != CV_DOWN) begin
         unique case (s.sp)
            SP_CMD: begin
               if (rise) begin
                  n.rx = {s.rx[21:0], s.din_s2};
                  n.cnt = s.cnt + 6'h01;
                  if (s.cnt == LEN_BYTE - 6'h01) begin
                     n.cnt = '0;
                     n.addr = by[5:0];
                     if (continuous_read_enable) begin
                        if (by == CMD_RD_DATA) begin
                           n.ifmode[IF_CONTINUOUS_READ_ENABLE] = 1'b0;
                           n.sp = SP_RD;
                           n.len = reg_len(A_DATA, app);
                           n.tx = tw;
                           n.rd_data = 1'b1;
                        end
                     end else if (by[RD_BIT]) begin
                        n.sp = SP_RD;
                        n.len = reg_len(by[5:0], app);
                        n.tx = tw;
                        n.rd_data = (by[5:0] == A_DATA);
                     end else begin
                        n.sp = SP_WR;
                        n.len = reg_len(by[5:0], app);
                     end
                  end
               end
            end
            SP_WR: begin
               if (rise) begin
                  n.rx = {s.rx[21:0], s.din_s2};
                  n.cnt = s.cnt + 6'h01;
                  if (s.cnt == s.len - 6'h01) begin
                     n.sp = SP_CMD;
                     n.cnt = '0;
                     wr = 1'b1;
                  end
               end
            end
            SP_RD: begin
               if (fall) begin
                  n.obit = s.tx[31];
                  n.tx = {s.tx[30:0], 1'b0};
                  n.cnt = s.cnt + 6'h01;
               end
               if (rise) begin
                  n.rx = {s.rx[21:0], s.din_s2};
                  if (continuous_read_enable && !s.rdy_b && s.cnt == LEN_BYTE && by == CMD_RD_DATA) begin
                     n.ifmode[IF_CONTINUOUS_READ_ENABLE] = 1'b0;
                     n.sp = SP_CMD;
                     n.cnt = '0;
                     n.rd_data = 1'b0;
                  end else if (s.cnt == s.len) begin
                     n.sp = SP_CMD;
                     n.cnt = '0;
                     n.rd_data = 1'b0;
                     if (s.rd_data) begin
                        n.rdy_b = 1'b1;
                     end
                  end
               end
            end
            default: begin
               n.sp = SP_CMD;
               n.cnt = '0;
            end
         endcase
      end

      // ==========================================================
      // register writes
      if (wr) begin
         case (s.addr)
            A_MODE: begin
               if (!(w[MODE_LSB +: 3] == M_PDOWN && !(mf == M_STANDBY && s.cv == CV_IDLE))) begin
                  n.mode = w;
                  mwr = 1'b1;
               end
            end
            A_IFMODE: begin
               n.ifmode = w;
               if (mf != M_CONT) begin
                  n.ifmode[IF_CONTINUOUS_READ_ENABLE] = 1'b0;
               end
            end
            A_CHEN: n.chen = w;
            A_OFFSET: if (!ical) n.offset = w;
            A_GAIN: if (!ical) n.gain = w;
            default: ;
         endcase
      end
      nmf = n.mode[MODE_LSB +: 3];
      if (mwr && nmf != M_CONT) begin
         n.ifmode[IF_CONTINUOUS_READ_ENABLE] = 1'b0;
      end

      // ==========================================================
      // conversion sequencing
      if (mwr || s.kick) begin
         n.kick = 1'b0;
         n.cur_ch = next_ch(n.chen, 4'hF);
         if (nmf == M_STANDBY) begin
            n.cv = CV_IDLE;
         end else if (nmf != M_PDOWN) begin
            n.cv = CV_RUN;
            n.conv_start = 1'b1;
            n.rdy_b = 1'b1;
         end
      end else if (s.cv == CV_RUN && conv_done) begin
         if (mf >= M_ICAL_Z) begin
            if (mf == M_ICAL_Z || mf == M_SCAL_Z) begin
               n.offset = conv_raw;
            end else begin
               n.gain = conv_raw;
            end
            n.rdy_b = 1'b0;
            n.mode[MODE_LSB +: 3] = M_STANDBY;
            n.cv = CV_IDLE;
         end else begin
            v = scale(conv_raw, s.offset, s.gain, s.ifmode[IF_UNIPOLAR]);
            if (!(s.sp == SP_RD && s.rd_data && !continuous_read_enable)) begin
               n.data = v;
               n.data_ch = s.cur_ch;
               n.rdy_b = 1'b0;
               if (continuous_read_enable) begin
                  n.sp = SP_RD;
                  n.cnt = '0;
                  n.len = reg_len(A_DATA, app);
                  n.tx = {v, 4'h0, s.cur_ch};
                  n.rd_data = 1'b1;
               end
            end
            nc = next_ch(s.chen, s.cur_ch);
            if (mf == M_SINGLE && nc <= s.cur_ch) begin
               n.cv = CV_IDLE;
               n.mode[MODE_LSB +: 3] = M_STANDBY;
            end else begin
               n.cur_ch = nc;
               n.conv_start = 1'b1;
            end
         end
      end

      // power-down wipes everything; serial reset restarts from power-on
      if (srst || (mwr && nmf == M_PDOWN)) begin
         t = RST;
         t.sclk_s1 = n.sclk_s1;
         t.sclk_s2 = n.sclk_s2;
         t.sclk_d = n.sclk_d;
         t.cs_s1 = n.cs_s1;
         t.cs_s2 = n.cs_s2;
         t.din_s1 = n.din_s1;
         t.din_s2 = n.din_s2;
         t.cv = srst ? CV_IDLE : CV_DOWN;
         t.kick = srst;
         n = t;
      end

      n.cal_zero = (n.cv == CV_RUN) && (n.mode[MODE_LSB +: 3] == M_ICAL_Z);
      n.cal_fs = (n.cv == CV_RUN) && (n.mode[MODE_LSB +: 3] == M_ICAL_F);
      n.clk_run = !(n.cv == CV_DOWN ||
                    (n.cv == CV_IDLE && n.mode[CLKSEL_LSB +: 2] == CLKSEL_INT));
      n.gpio_hiz = (n.cv == CV_DOWN);
      n.dout_oe = ~s.cs_s2;
      n.dout = (n.sp == SP_RD && n.cnt != 6'h00) ? n.obit : n.rdy_b;
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         s <= RST;
      end else if (ce) begin
         s <= n;
      end
   end

   assign conv_start = s.conv_start;
   assign conv_ch = s.cur_ch;
   assign cal_zero_route = s.cal_zero;
   assign cal_fs_route = s.cal_fs;
   assign clk_run = s.clk_run;
   assign gpio_hiz = s.gpio_hiz;
   assign link.dout = s.dout;
   assign link.dout_oe = s.dout_oe;
endmodule
`default_nettype wire

// ===== aomc_host.sv
// host end: serial master driven from a small register port
`default_nettype none
module aomc_host #(
   parameter int RESET_WAIT = aomc_pkg::RESET_WAIT_CYC
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   input wire logic ce,
   // register port
   input wire logic [3:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [31:0] rdata,
   // serial link
   aomc_link_if.host link
);
   import aomc_pkg::*;

   typedef struct packed {
      logic dout_s1;
      logic dout_s2;
      aomc_hp_e hp;
      logic [3:0] div;
      logic [6:0] bits;
      logic [6:0] nb;
      logic [39:0] sh;
      logic [31:0] rx;
      logic [31:0] txd;
      logic [15:0] wait_cnt;
      logic rst_seq;
      logic hold;
      logic cs_b;
      logic sclk;
      logic din;
      logic [31:0] rdata;
   } aomc_host_s;

   localparam aomc_host_s HRST = '{dout_s1: 1'b1, dout_s2: 1'b1, hp: H_IDLE, cs_b: 1'b1,
                                   sclk: 1'b1, default: '0};

   aomc_host_s s;
   aomc_host_s n;

   always_comb begin
      logic skip;
      logic [6:0] nb;
      skip = wdata[C_SKIP];
      nb = wdata[C_SRST] ? 7'(SRST_CLKS) : 7'(wdata[13:8]) + (skip ? 7'h00 : 7'h08);
      n = s;
      n.dout_s1 = link.dout_line;
      n.dout_s2 = s.dout_s1;
      n.rdata = '0;
      if (rd) begin
         case (addr)
            HA_RXD: n.rdata = s.rx;
            HA_STAT: n.rdata = {30'h0000_0000, ~s.dout_s2, s.hp != H_IDLE};
            default: ;
         endcase
      end
      if (wr && addr == HA_TXD) begin
         n.txd = wdata;
      end
      // orders arriving while busy are dropped
      if (wr && addr == HA_CTRL && s.hp == H_IDLE) begin
         n.hold = wdata[C_HOLD];
         n.cs_b = ~wdata[C_HOLD];
         n.rst_seq = wdata[C_SRST];
         n.nb = nb;
         n.bits = '0;
         n.div = '0;
         if (wdata[C_SRST]) begin
            n.sh = '1;
         end else begin
            n.sh = skip ? '0 : {wdata[7:0], s.txd};
         end
         if (nb != 7'h00) begin
            n.hp = H_XFER;
            n.cs_b = 1'b0;
         end
      end
      unique case (s.hp)
         H_IDLE: ;
         H_XFER: begin
            n.div = s.div + 4'h1;
            if (s.div == 4'(SCLK_HALF - 1)) begin
               n.div = '0;
               if (!s.sclk) begin
                  n.sclk = 1'b1;
                  n.rx = {s.rx[30:0], s.dout_s2};
                  n.bits = s.bits + 7'h01;
               end else if (s.bits == s.nb) begin
                  n.cs_b = ~s.hold;
                  n.din = 1'b0;
                  n.wait_cnt = '0;
                  n.hp = s.rst_seq ? H_WAIT : H_IDLE;
               end else begin
                  n.sclk = 1'b0;
                  n.din = s.sh[39];
                  n.sh = {s.sh[38:0], s.rst_seq};
               end
            end
         end
         H_WAIT: begin
            n.wait_cnt = s.wait_cnt + 16'h0001;
            if (s.wait_cnt == 16'(RESET_WAIT - 1)) begin
               n.hp = H_IDLE;
            end
         end
         default: n.hp = H_IDLE;
      endcase
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         s <= HRST;
      end else if (ce) begin
         s <= n;
      end
   end

   assign rdata = s.rdata;
   assign link.cs_b = s.cs_b;
   assign link.sclk = s.sclk;
   assign link.din = s.din;
endmodule
`default_nettype wire

// ===== aomc_asserts.sv
// checker: framing and drive rules on the serial link between both ends
`default_nettype none
module aomc_asserts (
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // link
   input wire logic cs_b,
   input wire logic sclk,
   input wire logic din,
   input wire logic dout,
   input wire logic dout_oe,
   input wire logic dout_line
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk);
   endclocking
   default disable iff (!rst_b);
   // ======================================
   // clock framing
   a_sclk_idle_high: assert property (cs_b |-> sclk)
      else $error("sclk moved while deselected");
   a_first_half: assert property ($fell(cs_b) |-> sclk [*8] ##1 !sclk)
      else $error("lead time before first fall wrong");
   a_low_half: assert property ($fell(sclk) |-> !sclk [*8] ##1 sclk)
      else $error("sclk low phase not 8 cycles");
   a_high_half: assert property ($rose(sclk) |-> sclk [*8])
      else $error("sclk high phase too short");
   a_cs_on_high: assert property ($changed(cs_b) |-> sclk)
      else $error("select moved with sclk low");
   a_din_on_low: assert property ($changed(din) |-> !sclk || cs_b)
      else $error("din moved while sclk high");
   a_idle_din_low: assert property (cs_b [*4] |-> !din)
      else $error("din not low while idle");
   // ======================================
   // data line drive
   a_oe_on_select: assert property ($fell(cs_b) |-> ##[1:4] dout_oe)
      else $error("line not driven after select");
   a_oe_off_release: assert property ($rose(cs_b) |-> ##[1:4] !dout_oe)
      else $error("line still driven after release");
   c_frame: cover property ($rose(cs_b));
   c_ready_low: cover property (!cs_b && dout_oe && !dout);
   c_line_low: cover property (!dout_line);
endmodule
`default_nettype wire

// ===== adc_operating_mode_control_test.sv
// testbench: host and converter ends joined by the link, filter modelled here
`default_nettype none
module adc_operating_mode_control_test;
   timeunit 1ns;
   timeprecision 1ps;
   import aomc_pkg::*;
   localparam int CONV = 300;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic [3:0] addr = 4'h0;
   logic [31:0] wdata = 32'h0;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic rd_seen = 1'b0;
   logic seq_on = 1'b0;
   logic conv_done = 1'b0;
   logic [23:0] conv_raw = 24'h0;
   logic [31:0] rdata;
   logic [23:0] raw;
   logic [23:0] v;
   logic conv_start, cal_z, cal_f, clk_run, gpio_hiz;
   logic [3:0] conv_ch;
   logic [3:0] prev_ch;
   int cnt, fails, n_compared;
   logic [23:0] exp_q[$];

   always #10 clk = ~clk;
   aomc_link_if link();
   aomc_dev i_aomc_dev (.clk(clk), .rst_b(rst_b), .ce(1'b1), .link(link.dev),
      .conv_done(conv_done), .conv_raw(conv_raw), .conv_start(conv_start), .conv_ch(conv_ch),
      .cal_zero_route(cal_z), .cal_fs_route(cal_f), .clk_run(clk_run), .gpio_hiz(gpio_hiz));
   aomc_host #(.RESET_WAIT(20)) i_aomc_host (.clk(clk), .rst_b(rst_b), .ce(1'b1),
      .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .link(link.host));
   aomc_asserts i_aomc_asserts (.clk(clk), .rst_b(rst_b), .cs_b(link.cs_b), .sclk(link.sclk),
      .din(link.din), .dout(link.dout), .dout_oe(link.dout_oe), .dout_line(link.dout_line));

   // ======================================
   // filter model: reloads on every start, so a restart drops the old one
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cnt <= 0;
         conv_done <= 1'b0;
      end else begin
         conv_done <= (cnt == 1);
         cnt <= conv_start ? CONV : (cnt != 0) ? cnt - 1 : 0;
         if (conv_start && seq_on) begin
            check(24'(conv_ch), (prev_ch == 4'h0) ? 24'h2 : 24'h0);
         end
         if (conv_start) begin
            prev_ch <= conv_ch;
         end
      end
   end

   // read data stand only in the cycle after the strobe
   always @(negedge clk) begin
      if (rd_seen) begin
         check(rdata[23:0], exp_q.pop_front());
      end
      rd_seen = rd;
   end

   // ======================================
   // tasks
   task automatic check(input logic [23:0] got, input logic [23:0] e);
      n_compared++;
      if (got !== e) begin
         fails++;
         $display("[ERR] %0t got %h exp %h", $time, got, e);
      end
   endtask
   task automatic conclude();
      if (fails == 0 && n_compared > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task automatic put(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic xfer(input logic [7:0] c, input logic [31:0] d, input logic [5:0] n,
                       input logic [31:0] x);
      int i;
      put(HA_TXD, d);
      put(HA_CTRL, x | {18'h0, n, c});
      for (i = 0; i < 20 && link.cs_b; i++) @(posedge clk);
      // a dropped order never selects the converter
      if (i == 20) begin
         fails++;
         conclude();
      end
      for (i = 0; i < 3000 && !link.cs_b; i++) @(posedge clk);
      if (i == 3000) begin
         fails++;
         conclude();
      end
      repeat (24) @(posedge clk);
   endtask
   task automatic rdv(input logic [5:0] n, input logic [23:0] e);
      xfer(CMD_RD_DATA, 32'h0, n, 32'h0);
      exp_q.push_back(e);
      @(posedge clk);
      addr <= HA_RXD;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
   endtask
   task automatic rreg(input logic [5:0] a, input logic [23:0] e);
      xfer({2'b01, a}, 32'h0, LEN_WORD, 32'h0);
      exp_q.push_back(e);
      @(posedge clk);
      addr <= HA_RXD;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
   endtask
   task automatic wreg(input logic [5:0] a, input logic [23:0] d);
      xfer({2'b00, a}, {d, 8'h00}, LEN_WORD, 32'h0);
   endtask
   function automatic logic [23:0] scl(input logic [23:0] r, input logic [23:0] o,
                                       input logic u);
      longint s;
      s = ((longint'(r) - (longint'(o) - longint'(MID_SCALE))) * longint'(GAIN_RST)) >>> 22;
      s = u ? s * 2 : s + longint'(MID_SCALE);
      return s[23:0];
   endfunction

   // ======================================
   // main sequence
   initial begin
      raw = 24'($urandom(32'hd846_b1c4));
      raw = 24'h01_0000 | (24'($urandom()) & 24'h0F_FFFF);
      repeat (3) @(posedge clk);
      rst_b <= 1'b1;
      conv_raw <= raw;
      repeat (2 * CONV) @(posedge clk);
      rdv(LEN_WORD, scl(raw, MID_SCALE, 1'b0));
      rreg(A_OFFSET, MID_SCALE);
      rreg(A_GAIN, GAIN_RST);
      wreg(A_IFMODE, 24'h00_0001);
      repeat (2 * CONV) @(posedge clk);
      rdv(LEN_WORD, scl(raw, MID_SCALE, 1'b1));
      wreg(A_IFMODE, 24'h00_0040);
      repeat (2 * CONV) @(posedge clk);
      v = scl(raw, MID_SCALE, 1'b0);
      rdv(LEN_DATA_ST, {v[15:0], 8'h00});
      wreg(A_IFMODE, 24'h00_0000);
      // offset first, then full scale; the reference never changes here
      wreg(A_MODE, {17'h0, M_ICAL_Z, 4'h0});
      check({22'h0, cal_f, cal_z}, 24'h1);
      repeat (CONV + 50) @(posedge clk);
      check({22'h0, cal_z, clk_run}, 24'h0);
      rreg(A_OFFSET, raw);
      wreg(A_MODE, {17'h0, M_ICAL_F, 4'h0});
      check({22'h0, cal_f, cal_z}, 24'h2);
      // command byte lands well before the calibration ends
      rreg(A_GAIN, 24'h00_0000);
      rreg(A_GAIN, raw);
      wreg(A_MODE, {17'h0, M_PDOWN, 4'h0});
      check(24'(gpio_hiz), 24'h1);
      xfer(8'h00, 32'h0, 6'h00, 32'h1 << C_SRST);
      check(24'(gpio_hiz), 24'h0);
      rreg(A_OFFSET, MID_SCALE);
      // power-down from continuous mode must be ignored
      wreg(A_MODE, {17'h0, M_PDOWN, 4'h0});
      check(24'(gpio_hiz), 24'h0);
      wreg(A_CHEN, 24'h00_0005);
      repeat (3 * CONV) @(posedge clk);
      seq_on <= 1'b1;
      repeat (6 * CONV) @(posedge clk);
      seq_on <= 1'b0;
      // two channels once each, then the mode field reads standby
      wreg(A_MODE, {17'h0, M_SINGLE, 4'h0});
      repeat (3 * CONV) @(posedge clk);
      rreg(A_MODE, {17'h0, M_STANDBY, 4'h0});
      repeat (4) @(posedge clk);
      conclude();
   end
endmodule
`default_nettype wire
